// >>> inc/ebc_defs.svh
// Offsets, reset values and timing counts of the external area bus setup
`ifndef EBC_DEFS_SVH
`define EBC_DEFS_SVH
`define EBC_ADDR_W 20
`define EBC_DATA_W 8
`define EBC_OFS_SEL_EN 20'hEE01F
`define EBC_OFS_WIDTH 20'hEE020
`define EBC_OFS_STATES 20'hEE021
`define EBC_OFS_WAIT_HI 20'hEE022
`define EBC_SEL_EN_RST 4'h0
`define EBC_SEL_RSVD 4'hF
`define EBC_WIDTH_8BIT 8'hFF
`define EBC_WIDTH_16BIT 8'h00
`define EBC_STATES_RST 8'hFF
`define EBC_WAIT_HI_RST 8'hFF
`define EBC_MODE_A 3'h1
`define EBC_MODE_B 3'h3
`define EBC_LOW_WAIT_DEF 8'h00
`define EBC_TWO_STATES 3'h2
`define EBC_THREE_STATES 3'h3
`define EBC_RDATA_IDLE 8'h00
`endif

// >>> inc/ebc_pkg.sv
// Types shared by the external area bus setup block
package ebc_pkg;
  typedef struct packed {
    logic w8;
    logic three;
    logic [1:0] waits;
    logic sel_en;
  } ebc_area_cfg_t;

  typedef enum logic [1:0] {
    EBC_IDLE = 2'b01,
    EBC_RUN = 2'b10
  } ebc_tmr_st_t;

  typedef struct packed {
    ebc_tmr_st_t st;
    logic [2:0] left;
  } ebc_tmr_t;

  typedef struct packed {
    logic [3:0] sel_en;
    logic [7:0] width;
    logic [7:0] states;
    logic [7:0] waits_hi;
    logic init_done;
    logic [7:0] rdata;
    ebc_area_cfg_t cur;
    logic [2:0] cur_area;
    logic [3:0] oe;
  } ebc_state_t;
endpackage : ebc_pkg

// >>> rtl/ebc_area_sel.sv
// Per-area setting lookup for the area of a starting bus cycle
`timescale 1ns/10ps
`default_nettype none
`include "ebc_defs.svh"
module ebc_area_sel #(
  parameter logic [7:0] LOW_WAIT = `EBC_LOW_WAIT_DEF
) (
  input wire logic [7:0] width_i,
  input wire logic [7:0] states_i,
  input wire logic [7:0] waits_hi_i,
  input wire logic [3:0] sel_en_i,
  input wire logic [2:0] area_i,
  output var ebc_pkg::ebc_area_cfg_t cfg_o
);
  ebc_pkg::ebc_area_cfg_t tbl [8];

  for (genvar g = 0; g < 8; g++) begin : g_area
    assign tbl[g].w8 = width_i[g];
    assign tbl[g].three = states_i[g];
    if (g >= 4) begin : g_hi
      // Area 7 in bits 7-6 down to area 4 in bits 1-0
      assign tbl[g].waits = waits_hi_i[2*(g-4) +: 2];
      assign tbl[g].sel_en = sel_en_i[g-4];
    end else begin : g_lo
      // Lower areas have no select line in this block
      assign tbl[g].waits = LOW_WAIT[2*g +: 2];
      assign tbl[g].sel_en = 1'b0;
    end
  end

  assign cfg_o = tbl[area_i];
endmodule : ebc_area_sel
`default_nettype wire

// >>> rtl/ebc_acc_timer.sv
// Counts the states of one external access
`timescale 1ns/10ps
`default_nettype none
`include "ebc_defs.svh"
module ebc_acc_timer (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  input wire ebc_pkg::ebc_area_cfg_t cfg_i,
  output logic busy_o,
  output logic last_o
);
  ebc_pkg::ebc_tmr_t q, d;
  logic [2:0] total;

  // Base length plus programmed waits, 2 to 6 states
  assign total = (cfg_i.three ? `EBC_THREE_STATES : `EBC_TWO_STATES) + {1'b0, cfg_i.waits};

  always_comb begin
    d = q;
    case (q.st)
      ebc_pkg::EBC_IDLE: begin
        if (start_i) begin
          d.st = ebc_pkg::EBC_RUN;
          d.left = total - 3'h1;
        end
      end
      ebc_pkg::EBC_RUN: begin
        if (q.left == 3'h0) begin
          d.st = ebc_pkg::EBC_IDLE;
        end else begin
          d.left = q.left - 3'h1;
        end
      end
      default: begin
        d.st = ebc_pkg::EBC_IDLE;
        d.left = 3'h0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '{st: ebc_pkg::EBC_IDLE, left: 3'h0};
    end else begin
      q <= d;
    end
  end

  assign busy_o = (q.st == ebc_pkg::EBC_RUN);
  assign last_o = busy_o && (q.left == 3'h0);

  sequence go_s(int n);
    start_i && !busy_o && (total == n);
  endsequence

  len_long_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    go_s(6) |=> busy_o [*6] ##1 !busy_o) else $error("six state access length wrong");
  len_short_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    go_s(2) |=> busy_o [*2] ##1 !busy_o) else $error("two state access length wrong");
endmodule : ebc_acc_timer
`default_nettype wire

// >>> rtl/ebc_cfg_top.sv
// External area bus setup registers with access timing and select lines
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "ebc_defs.svh"
module ebc_cfg_top #(
  parameter logic [7:0] LOW_WAIT = `EBC_LOW_WAIT_DEF
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [2:0] mode_i,
  input wire logic [`EBC_ADDR_W-1:0] reg_addr_i,
  input wire logic [`EBC_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`EBC_DATA_W-1:0] reg_rdata_o,
  input wire logic cyc_start_i,
  input wire logic [2:0] cyc_area_i,
  output logic cyc_busy_o,
  output logic cyc_last_o,
  output logic cyc_w8_o,
  output logic cyc_three_o,
  output logic [1:0] cyc_waits_o,
  output logic [3:0] area_sel_line_n_o,
  output logic [3:0] area_sel_line_oe_o
);
  ebc_pkg::ebc_state_t q, d;
  ebc_pkg::ebc_area_cfg_t sel_cfg;
  logic busy;
  logic last;
  logic take;
  logic wr_sel, wr_width, wr_states, wr_wait;
  logic [7:0] rd_val;

  ebc_area_sel #(
    .LOW_WAIT(LOW_WAIT)
  ) u_sel (
    .width_i(q.width),
    .states_i(q.states),
    .waits_hi_i(q.waits_hi),
    .sel_en_i(q.sel_en),
    .area_i(cyc_area_i),
    .cfg_o(sel_cfg)
  );

  // Cycle start is ignored while an access runs
  assign take = cyc_start_i && !busy;

  ebc_acc_timer u_tmr (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .start_i(take),
    .cfg_i(sel_cfg),
    .busy_o(busy),
    .last_o(last)
  );

  assign wr_sel = reg_wr_i && (reg_addr_i == `EBC_OFS_SEL_EN);
  assign wr_width = reg_wr_i && (reg_addr_i == `EBC_OFS_WIDTH);
  assign wr_states = reg_wr_i && (reg_addr_i == `EBC_OFS_STATES);
  assign wr_wait = reg_wr_i && (reg_addr_i == `EBC_OFS_WAIT_HI);

  always_comb begin
    case (reg_addr_i)
      `EBC_OFS_SEL_EN: rd_val = {q.sel_en, `EBC_SEL_RSVD};
      `EBC_OFS_WIDTH: rd_val = q.width;
      `EBC_OFS_STATES: rd_val = q.states;
      `EBC_OFS_WAIT_HI: rd_val = q.waits_hi;
      default: rd_val = `EBC_RDATA_IDLE;
    endcase
  end

  always_comb begin
    d = q;
    // Mode is sampled once, one edge after reset release
    if (!q.init_done) begin
      d.init_done = 1'b1;
      if ((mode_i == `EBC_MODE_A) || (mode_i == `EBC_MODE_B)) begin
        d.width = `EBC_WIDTH_8BIT;
      end else begin
        d.width = `EBC_WIDTH_16BIT;
      end
    end
    if (wr_sel) begin
      d.sel_en = reg_wdata_i[7:4];
    end
    if (wr_width) begin
      d.width = reg_wdata_i;
    end
    if (wr_states) begin
      d.states = reg_wdata_i;
    end
    if (wr_wait) begin
      d.waits_hi = reg_wdata_i;
    end
    d.rdata = reg_rd_i ? rd_val : `EBC_RDATA_IDLE;
    // Settings are frozen for the whole access
    if (take) begin
      d.cur = sel_cfg;
      d.cur_area = cyc_area_i;
    end
    // Enables change only between accesses, never mid-cycle
    if (!busy) begin
      d.oe = q.sel_en;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '{
        sel_en: `EBC_SEL_EN_RST,
        width: `EBC_WIDTH_16BIT,
        states: `EBC_STATES_RST,
        waits_hi: `EBC_WAIT_HI_RST,
        init_done: 1'b0,
        rdata: `EBC_RDATA_IDLE,
        cur: '0,
        cur_area: 3'h0,
        oe: `EBC_SEL_EN_RST
      };
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign cyc_busy_o = busy;
  assign cyc_last_o = last;
  assign cyc_w8_o = q.cur.w8;
  assign cyc_three_o = q.cur.three;
  assign cyc_waits_o = q.cur.waits;

  for (genvar i = 0; i < 4; i++) begin : g_line
    // Line i serves area 4 + i; driven low only while its access runs
    assign area_sel_line_n_o[i] = !(busy && q.oe[i] && (q.cur_area == 3'(4 + i)));
    assign area_sel_line_oe_o[i] = q.oe[i];
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence acc_s;
    cyc_start_i && !busy;
  endsequence

  sequence run_s;
    busy && !last;
  endsequence

  sequence rd_s(logic [`EBC_ADDR_W-1:0] a);
    reg_rd_i && (reg_addr_i == a);
  endsequence

  line_gate_a: assert property (
    (~area_sel_line_oe_o & ~area_sel_line_n_o) == 4'h0
  ) else $error("select line driven while disabled");

  line_active_a: assert property (
    busy && q.oe[3] && (q.cur_area == 3'h7) |-> !area_sel_line_n_o[3]
  ) else $error("enabled select line not driven during access");

  oe_hold_a: assert property (
    run_s |=> $stable(area_sel_line_oe_o)
  ) else $error("select enable changed inside an access");

  rsvd_ones_a: assert property (
    rd_s(`EBC_OFS_SEL_EN) |=> reg_rdata_o[3:0] == 4'hF
  ) else $error("reserved enable bits not read as ones");

  sel_echo_a: assert property (
    wr_sel ##1 rd_s(`EBC_OFS_SEL_EN) |=> reg_rdata_o[7:4] == $past(reg_wdata_i[7:4], 2)
  ) else $error("enable bits not written");

  sel_rst_a: assert property (
    !q.init_done |-> q.sel_en == 4'h0
  ) else $error("enable bits not cleared by reset");

  width_pick_a: assert property (
    acc_s |=> cyc_w8_o == $past(q.width[cyc_area_i])
  ) else $error("access width not taken from its area");

  width_mode_a: assert property (
    !q.init_done && !wr_width && ((mode_i == 3'h1) || (mode_i == 3'h3))
      |=> q.width == 8'hFF
  ) else $error("width reset wrong for narrow modes");

  width_wide_a: assert property (
    !q.init_done && !wr_width && (mode_i != 3'h1) && (mode_i != 3'h3)
      |=> q.width == 8'h00
  ) else $error("width reset wrong for wide modes");

  state_pick_a: assert property (
    acc_s |=> cyc_three_o == $past(q.states[cyc_area_i])
  ) else $error("state count not taken from its area");

  state_rst_a: assert property (
    !q.init_done |-> q.states == 8'hFF
  ) else $error("state bits not set by reset");

  state_echo_a: assert property (
    wr_states ##1 rd_s(`EBC_OFS_STATES) |=> reg_rdata_o == $past(reg_wdata_i, 2)
  ) else $error("state bits not read back");

  wait_map_a: assert property (
    acc_s and (cyc_area_i == 3'h7) |=> cyc_waits_o == $past(q.waits_hi[7:6])
  ) else $error("area 7 wait field misplaced");

  wait_low_a: assert property (
    acc_s and (cyc_area_i == 3'h4) |=> cyc_waits_o == $past(q.waits_hi[1:0])
  ) else $error("area 4 wait field misplaced");

  wait_rst_a: assert property (
    !q.init_done |-> q.waits_hi == 8'hFF
  ) else $error("wait fields not set by reset");

  cfg_hold_a: assert property (
    run_s |=> $stable(cyc_w8_o) && $stable(cyc_three_o) && $stable(cyc_waits_o)
  ) else $error("access setting changed inside an access");

  unmapped_a: assert property (
    reg_rd_i && !(reg_addr_i inside {`EBC_OFS_SEL_EN, `EBC_OFS_WIDTH,
      `EBC_OFS_STATES, `EBC_OFS_WAIT_HI}) |=> reg_rdata_o == 8'h00
  ) else $error("unmapped read not zero");

  sequence idle_s;
    !busy;
  endsequence

  sequence pick_s(logic [2:0] a);
    acc_s and (cyc_area_i == a);
  endsequence

  // One check set per area so a swapped bit of any area shows
  for (genvar g = 0; g < 8; g++) begin : g_area_chk
    area_width_a: assert property (
      pick_s(3'(g)) |=> cyc_w8_o == $past(q.width[g])
    ) else $error("area width bit misplaced");

    area_states_a: assert property (
      pick_s(3'(g)) |=> cyc_three_o == $past(q.states[g])
    ) else $error("area state bit misplaced");

    area_start_a: assert property (
      pick_s(3'(g)) |=> cyc_busy_o
    ) else $error("taken start did not begin an access");

    if (g >= 4) begin : g_hi
      area_wait_a: assert property (
        pick_s(3'(g)) |=> cyc_waits_o == $past(q.waits_hi[2*(g-4) +: 2])
      ) else $error("upper area wait field misplaced");
    end else begin : g_lo
      // Lower areas take their waits from the build-time value
      low_wait_a: assert property (
        pick_s(3'(g)) |=> cyc_waits_o == LOW_WAIT[2*g +: 2]
      ) else $error("lower area wait value wrong");
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_line_chk
    line_off_a: assert property (
      !area_sel_line_oe_o[i] |-> area_sel_line_n_o[i]
    ) else $error("disabled select line pulled low");

    line_idle_a: assert property (
      idle_s |-> area_sel_line_n_o[i]
    ) else $error("select line low outside an access");

    line_on_a: assert property (
      busy && q.oe[i] && (q.cur_area == 3'(4 + i)) |-> !area_sel_line_n_o[i]
    ) else $error("enabled select line not driven");
  end

  oe_follow_a: assert property (
    idle_s |=> area_sel_line_oe_o == $past(q.sel_en)
  ) else $error("select enable not taken between accesses");

  rdata_idle_a: assert property (
    !reg_rd_i |=> reg_rdata_o == 8'h00
  ) else $error("read data not idle");

  width_echo_a: assert property (
    wr_width ##1 rd_s(`EBC_OFS_WIDTH) |=> reg_rdata_o == $past(reg_wdata_i, 2)
  ) else $error("width bits not read back");

  wait_echo_a: assert property (
    wr_wait ##1 rd_s(`EBC_OFS_WAIT_HI) |=> reg_rdata_o == $past(reg_wdata_i, 2)
  ) else $error("wait fields not read back");

  last_end_a: assert property (
    cyc_last_o |=> !cyc_busy_o
  ) else $error("access ran past its last state");
endmodule : ebc_cfg_top
`default_nettype wire

// >>> tb/ebc_ext_dev.sv
// Behavioural external device that watches the area select lines
`timescale 1ns/10ps
`default_nettype none
module ebc_ext_dev (
  input wire logic mclk_i,
  input wire logic clr_i,
  input wire logic [3:0] sel_n_i,
  input wire logic [3:0] sel_oe_i,
  output logic [3:0] len_o,
  output logic [3:0] seen_o
);
  logic [3:0] low;
  // Undriven lines float to the pull-up level
  assign low = ~((sel_n_i & sel_oe_i) | ~sel_oe_i);
  always_ff @(posedge mclk_i) begin
    if (clr_i) begin
      len_o <= 4'h0;
      seen_o <= 4'h0;
    end else if (|low) begin
      len_o <= len_o + 4'h1;
      seen_o <= seen_o | low;
    end
  end
endmodule : ebc_ext_dev
`default_nettype wire

// >>> tb/ebc_cfg_top_tb.sv
// Self-checking bench for the external area bus setup block
`timescale 1ns/10ps
`default_nettype none
`include "ebc_defs.svh"
module ebc_cfg_top_tb;
  typedef struct packed {
    logic [19:0] a;
    logic [7:0] w;
    logic [7:0] r;
  } ebc_reg_row_t;
  typedef struct packed {
    logic [2:0] area;
    logic [3:0] n;
    logic w8;
    logic three;
    logic [1:0] waits;
    logic [3:0] line;
  } ebc_acc_row_t;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [2:0] mode_i = 3'h1;
  logic [`EBC_ADDR_W-1:0] reg_addr_i = 20'h00000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic cyc_start_i = 1'b0;
  logic [2:0] cyc_area_i = 3'h0;
  logic dev_clr = 1'b0;
  logic [7:0] rdata;
  logic busy, last, w8, three;
  logic [1:0] waits;
  logic [3:0] sel_n, sel_oe, dev_len, dev_seen;
  int mismatches = 0;
  int checked = 0;
  ebc_reg_row_t regs [5] = '{
    '{20'hEE01F, 8'hA0, 8'hAF}, '{20'hEE020, 8'h5A, 8'h5A},
    '{20'hEE021, 8'hA0, 8'hA0}, '{20'hEE022, 8'hE4, 8'hE4},
    '{20'hEE030, 8'h55, 8'h00}};
  ebc_acc_row_t accs [6] = '{
    '{3'h7, 4'h6, 1'h0, 1'h1, 2'h3, 4'h8}, '{3'h6, 4'h4, 1'h1, 1'h0, 2'h2, 4'h0},
    '{3'h5, 4'h4, 1'h0, 1'h1, 2'h1, 4'h2}, '{3'h4, 4'h2, 1'h1, 1'h0, 2'h0, 4'h0},
    '{3'h0, 4'h5, 1'h0, 1'h0, 2'h3, 4'h0}, '{3'h3, 4'h2, 1'h1, 1'h0, 2'h0, 4'h0}};

  // Low-area waits differ per area so a swapped field shows
  ebc_cfg_top #(.LOW_WAIT(8'h1B)) uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .mode_i(mode_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
    .cyc_start_i(cyc_start_i), .cyc_area_i(cyc_area_i), .cyc_busy_o(busy),
    .cyc_last_o(last), .cyc_w8_o(w8), .cyc_three_o(three), .cyc_waits_o(waits),
    .area_sel_line_n_o(sel_n), .area_sel_line_oe_o(sel_oe));
  ebc_ext_dev dev (.mclk_i(mclk_i), .clr_i(dev_clr), .sel_n_i(sel_n),
    .sel_oe_i(sel_oe), .len_o(dev_len), .seen_o(dev_seen));

  always #10 mclk_i = ~mclk_i;

  task automatic give_verdict();
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic do_reset(input logic [2:0] m);
    @(posedge mclk_i);
    arst_n_i <= 1'b0;
    mode_i <= m;
    repeat (3) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
  endtask : do_reset

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [19:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    chk("rdata", rdata, exp);
  endtask : rdc

  // Held start while busy must be ignored without stretching the access
  task automatic acc(input ebc_acc_row_t r, input logic held);
    int n = 0;
    int lp = -1;
    @(posedge mclk_i);
    cyc_start_i <= 1'b1;
    cyc_area_i <= r.area;
    dev_clr <= 1'b1;
    @(posedge mclk_i);
    cyc_start_i <= held;
    dev_clr <= 1'b0;
    if (held) begin
      @(posedge mclk_i);
      cyc_start_i <= 1'b0;
      n = 1;
    end
    for (int i = 0; i < 9; i++) begin
      @(negedge mclk_i);
      if (busy === 1'b1) n++;
      if (last === 1'b1) lp = n;
    end
    chk("busy_len", 8'(n), 8'(r.n));
    chk("last_pos", 8'(lp), 8'(r.n));
    chk("w8", 8'(w8), 8'(r.w8));
    chk("three", 8'(three), 8'(r.three));
    chk("waits", 8'(waits), 8'(r.waits));
    chk("sel_seen", 8'(dev_seen), 8'(r.line));
    chk("sel_len", 8'(dev_len), (r.line != 4'h0) ? 8'(r.n) : 8'h00);
  endtask : acc

  initial begin
    do_reset(3'h1);
    chk("oe_rst", 8'(sel_oe), 8'h00);
    chk("seln_rst", 8'(sel_n), 8'h0F);
    rdc(20'hEE01F, 8'h0F);
    rdc(20'hEE021, 8'hFF);
    rdc(20'hEE022, 8'hFF);
    for (int m = 0; m <= 4; m++) begin
      do_reset(3'(m));
      rdc(20'hEE020, m[0] ? 8'hFF : 8'h00);
    end
    foreach (regs[i]) begin
      wr(regs[i].a, regs[i].w);
      rdc(regs[i].a, regs[i].r);
    end
    chk("oe_on", 8'(sel_oe), 8'h0A);
    foreach (accs[i]) acc(accs[i], 1'b0);
    acc(accs[0], 1'b1);
    // Writes landing mid-access must not touch the running access
    fork
      acc(accs[0], 1'b0);
      begin
        repeat (2) @(posedge mclk_i);
        wr(20'hEE022, 8'h00);
        wr(20'hEE01F, 8'h00);
        @(negedge mclk_i);
        chk("oe_busy", 8'(sel_oe), 8'h0A);
      end
    join
    chk("oe_off", 8'(sel_oe), 8'h00);
    acc('{3'h7, 4'h3, 1'h0, 1'h1, 2'h0, 4'h0}, 1'b0);
    give_verdict();
  end

  initial begin
    #40000;
    mismatches++;
    give_verdict();
  end
endmodule : ebc_cfg_top_tb
`default_nettype wire
